/* verilog/cxe_pkg.sv */
// Purpose: Shared constants for the coprocessor handshake and exception entry sequencer
// Assumes: Single 200 MHz clock, synchronous active-high reset
// Notes: Cycle type codes match the next-cycle type output encoding
package cxe_pkg;
   // ------------------------------------------------------------
   // Cycle type encoding
   // ------------------------------------------------------------
   localparam logic [1:0] CXE_CYC_IDLE = 2'h0;
   localparam logic [1:0] CXE_CYC_COPROC = 2'h1;
   localparam logic [1:0] CXE_CYC_NONSEQ = 2'h2;
   localparam logic [1:0] CXE_CYC_SEQ = 2'h3;
   // ------------------------------------------------------------
   // Operation codes
   // ------------------------------------------------------------
   localparam logic [2:0] CXE_OP_DATA = 3'h0;
   localparam logic [2:0] CXE_OP_LOAD = 3'h1;
   localparam logic [2:0] CXE_OP_STORE = 3'h2;
   localparam logic [2:0] CXE_OP_TOCORE = 3'h3;
   localparam logic [2:0] CXE_OP_TOCP = 3'h4;
   localparam logic [2:0] CXE_OP_SWAP = 3'h5;
   localparam logic [2:0] CXE_OP_TRAP = 3'h6;
   localparam logic [2:0] CXE_OP_UNDEF = 3'h7;
   // ------------------------------------------------------------
   // Widths, offsets, reset values
   // ------------------------------------------------------------
   localparam int CXE_DW = 32;
   localparam logic [31:0] CXE_WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] CXE_ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] CXE_VEC_UNDEF = 32'h0000_0004;
   localparam logic [4:0] CXE_MODE_UNDEF = 5'h1b;
   localparam logic [4:0] CXE_MODE_SVC = 5'h13;
   localparam logic [4:0] CXE_MODE_USR = 5'h10;
   localparam logic [31:0] CXE_STATUS_RST = 32'h0000_00d3;
   localparam int CXE_TBIT_POS = 5;
   localparam int CXE_MODE_LSB = 0;
   // ------------------------------------------------------------
   // States, one-hot
   // ------------------------------------------------------------
   typedef enum logic [10:0] {
      CXE_IDLE = 11'h001,
      CXE_HAND = 11'h002,
      CXE_XFER = 11'h004,
      CXE_MOVE2 = 11'h008,
      CXE_MOVE3 = 11'h010,
      CXE_SWRD = 11'h020,
      CXE_SWWR = 11'h040,
      CXE_SWEND = 11'h080,
      CXE_EXC1 = 11'h100,
      CXE_EXC2 = 11'h200,
      CXE_UND2 = 11'h400
   } cxe_state_e;
endpackage : cxe_pkg

/* verilog/cxe_resp_sample.sv */
// Purpose: Registered capture of the coprocessor absent and busy responses
// Assumes: Responses are synchronous to ref_clk
// Notes: Reset value is high, the no-coprocessor answer
`timescale 1ns/1ps
module cxe_resp_sample
   import cxe_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic resp_in, // Response from coprocessor
   output logic resp_reg // Registered response
);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         resp_reg <= 1'b1;
      end else begin
         resp_reg <= resp_in;
      end
   end
endmodule : cxe_resp_sample

/* verilog/cxe_addr_gen.sv */
// Purpose: Word address counter for burst and vector fetches
// Assumes: Word transfers only
// Notes: Load has priority over step
`timescale 1ns/1ps
module cxe_addr_gen
   import cxe_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic load, // Load a new base
   input wire logic [31:0] load_val, // Base to load
   input wire logic step, // Advance one word
   output logic [31:0] addr_reg // Current address
);
   logic [31:0] addr_next;
   assign addr_next = load ? load_val : (step ? addr_reg + CXE_WORD_STEP : addr_reg);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_reg <= CXE_ADDR_RST;
      end else begin
         addr_reg <= addr_next;
      end
   end
endmodule : cxe_addr_gen

/* verilog/cxe_seq.sv */
// Purpose: Coprocessor handshake, locked swap tail and exception entry sequencer
// Assumes: Responses and interrupt synchronous to ref_clk; one op request at a time
// Notes: Outputs describe the next bus cycle, as the core's address-class outputs do
`timescale 1ns/1ps
module cxe_seq
   import cxe_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic op_valid, // Start operation pulse
   input wire logic [2:0] op_code, // Operation kind
   input wire logic compressed_state, // Core in 16-bit state
   input wire logic [31:0] pc_base, // Instruction address base
   input wire logic [31:0] data_addr, // Transfer or swap address
   input wire logic [31:0] src_data, // Core register for moves and swap
   input wire logic [31:0] vector_addr, // Trap vector address
   input wire logic [4:0] exc_mode, // Target exception mode
   input wire logic [1:0] ret_kind, // 0 trap, 1 prefetch abort, 2 data abort
   input wire logic [31:0] status_word, // Current status word
   input wire logic irq_pending, // Interrupt pending
   input wire logic coprocessor_absent, // Absent response
   input wire logic coprocessor_busy, // Busy response
   input wire logic [31:0] read_data, // Memory or coprocessor read data
   output logic [1:0] next_cycle_type, // Next cycle type
   output logic [31:0] bus_addr, // Bus address
   output logic bus_write, // Write indicator
   output logic bus_lock, // Locked access
   output logic priv_access, // Privileged access
   output logic coproc_issue_n, // Coprocessor instruction qualifier
   output logic [31:0] wdata_reg, // Write data
   output logic [31:0] link_register, // Saved return address
   output logic [31:0] saved_status_word, // Saved status word
   output logic [4:0] mode_reg, // Processor mode
   output logic tbit_reg, // Instruction set flag
   output logic [31:0] dest_reg, // Destination register value
   output logic dest_we, // Destination write pulse
   output logic base_wb, // Base write-back pulse
   output logic abandoned, // Busy-wait abandoned pulse
   output logic busy_seq // Sequence running
);
   // ------------------------------------------------------------
   // Response sampling and address counter
   // ------------------------------------------------------------
   logic cpa_s, cpb_s;
   cxe_resp_sample u_absent (
      .ref_clk(ref_clk),
      .rst(rst),
      .resp_in(coprocessor_absent),
      .resp_reg(cpa_s)
   );
   cxe_resp_sample u_busy (
      .ref_clk(ref_clk),
      .rst(rst),
      .resp_in(coprocessor_busy),
      .resp_reg(cpb_s)
   );
   cxe_state_e state_reg, state_next;
   logic [2:0] op_reg;
   logic addr_load, addr_step;
   logic [31:0] addr_load_val, addr_cur;
   cxe_addr_gen u_addr (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(addr_load),
      .load_val(addr_load_val),
      .step(addr_step),
      .addr_reg(addr_cur)
   );
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire is_cp_op = (op_code <= CXE_OP_TOCP);
   wire bad_state = compressed_state && (is_cp_op || op_code == CXE_OP_SWAP);
   wire start_undef = op_valid && (bad_state || op_code == CXE_OP_UNDEF);
   wire start_cp = op_valid && !bad_state && is_cp_op;
   wire start_swap = op_valid && !bad_state && op_code == CXE_OP_SWAP;
   wire start_trap = op_valid && op_code == CXE_OP_TRAP;
   wire in_hand = (state_reg == CXE_HAND);
   wire cp_refuse = in_hand && cpa_s && cpb_s;
   wire cp_wait = in_hand && !cpa_s && cpb_s;
   wire cp_commit = in_hand && !cpa_s && !cpb_s;
   wire cp_abandon = cp_wait && irq_pending;
   wire is_mem_op = (op_reg == CXE_OP_LOAD) || (op_reg == CXE_OP_STORE);
   wire last_xfer = (state_reg == CXE_XFER) && cpa_s && cpb_s;
   wire [31:0] ret_base = (ret_kind == 2'h2) ? pc_base + CXE_WORD_STEP : pc_base;
   logic exc_start;
   assign exc_start = start_trap || cp_refuse || (state_reg == CXE_UND2);
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CXE_IDLE: begin
            if (start_undef) begin
               state_next = CXE_UND2;
            end else if (start_cp) begin
               state_next = CXE_HAND;
            end else if (start_swap) begin
               state_next = CXE_SWRD;
            end else if (start_trap) begin
               state_next = CXE_EXC1;
            end
         end
         CXE_HAND: begin
            if (cp_refuse) begin
               state_next = CXE_UND2;
            end else if (cp_abandon) begin
               state_next = CXE_IDLE;
            end else if (cp_commit) begin
               if (is_mem_op) begin
                  state_next = CXE_XFER;
               end else if (op_reg == CXE_OP_DATA) begin
                  state_next = CXE_IDLE;
               end else begin
                  state_next = CXE_MOVE2;
               end
            end
         end
         CXE_XFER: begin
            if (last_xfer) begin
               state_next = CXE_IDLE;
            end
         end
         CXE_MOVE2: begin
            state_next = (op_reg == CXE_OP_TOCORE) ? CXE_MOVE3 : CXE_IDLE;
         end
         CXE_MOVE3: state_next = CXE_IDLE;
         CXE_SWRD: state_next = CXE_SWWR;
         CXE_SWWR: state_next = CXE_SWEND;
         CXE_SWEND: state_next = CXE_IDLE;
         CXE_UND2: state_next = CXE_EXC1;
         CXE_EXC1: state_next = CXE_EXC2;
         CXE_EXC2: state_next = CXE_IDLE;
         default: state_next = CXE_IDLE;
      endcase
   end
   // ------------------------------------------------------------
   // Address counter control
   // ------------------------------------------------------------
   assign addr_load = (start_swap && state_reg == CXE_IDLE) || (cp_commit && is_mem_op) ||
      (state_reg == CXE_UND2) || (start_trap && state_reg == CXE_IDLE);
   assign addr_load_val = (state_reg == CXE_UND2 || start_trap) ? vector_addr : data_addr;
   assign addr_step = (state_reg == CXE_XFER) || (state_reg == CXE_EXC1);
   // ------------------------------------------------------------
   // Next-cycle outputs, combinational from state, decoded requests and sampled responses
   // ------------------------------------------------------------
   always_comb begin
      next_cycle_type = CXE_CYC_IDLE;
      bus_addr = pc_base;
      bus_write = 1'b0;
      bus_lock = 1'b0;
      priv_access = (mode_reg != CXE_MODE_USR);
      coproc_issue_n = 1'b1;
      case (state_reg)
         CXE_IDLE: begin
            if (start_cp) begin
               coproc_issue_n = 1'b0;
               next_cycle_type = CXE_CYC_IDLE;
            end else if (start_undef) begin
               // Never offered to a coprocessor in compressed state
               coproc_issue_n = compressed_state;
            end
         end
         CXE_HAND: begin
            coproc_issue_n = 1'b0;
            if (cp_commit) begin
               if (is_mem_op) begin
                  next_cycle_type = CXE_CYC_NONSEQ;
               end else if (op_reg == CXE_OP_DATA) begin
                  next_cycle_type = CXE_CYC_NONSEQ;
               end else begin
                  next_cycle_type = CXE_CYC_COPROC;
               end
            end
         end
         CXE_XFER: begin
            coproc_issue_n = 1'b1;
            bus_addr = addr_cur;
            bus_write = (op_reg == CXE_OP_STORE);
            next_cycle_type = last_xfer ? CXE_CYC_NONSEQ : CXE_CYC_SEQ;
         end
         CXE_MOVE2: begin
            bus_write = (op_reg == CXE_OP_TOCP);
            next_cycle_type = (op_reg == CXE_OP_TOCORE) ? CXE_CYC_IDLE : CXE_CYC_NONSEQ;
         end
         CXE_MOVE3: next_cycle_type = CXE_CYC_SEQ;
         CXE_SWRD: begin
            bus_addr = addr_cur;
            bus_lock = 1'b1;
            next_cycle_type = CXE_CYC_NONSEQ;
         end
         CXE_SWWR: begin
            bus_addr = addr_cur;
            bus_write = 1'b1;
            bus_lock = 1'b1;
            next_cycle_type = CXE_CYC_IDLE;
         end
         CXE_SWEND: next_cycle_type = CXE_CYC_SEQ;
         CXE_UND2: next_cycle_type = CXE_CYC_NONSEQ;
         CXE_EXC1: begin
            bus_addr = addr_cur;
            priv_access = 1'b1;
            next_cycle_type = CXE_CYC_SEQ;
         end
         CXE_EXC2: begin
            bus_addr = addr_cur;
            priv_access = 1'b1;
            next_cycle_type = CXE_CYC_SEQ;
         end
         default: next_cycle_type = CXE_CYC_IDLE;
      endcase
   end
   // ------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= CXE_IDLE;
         op_reg <= CXE_OP_DATA;
      end else begin
         state_reg <= state_next;
         if (op_valid && state_reg == CXE_IDLE) begin
            op_reg <= op_code;
         end
      end
   end
   // ------------------------------------------------------------
   // Exception entry: link, status, mode, flag
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         link_register <= CXE_ADDR_RST;
         saved_status_word <= CXE_STATUS_RST;
         mode_reg <= CXE_MODE_SVC;
         tbit_reg <= 1'b0;
      end else if (exc_start && state_reg != CXE_EXC1) begin
         link_register <= ret_base;
         saved_status_word <= status_word;
         mode_reg <= (state_reg == CXE_UND2 || cp_refuse) ? CXE_MODE_UNDEF : exc_mode;
         tbit_reg <= 1'b0;
      end else if (state_reg == CXE_IDLE && op_valid) begin
         tbit_reg <= compressed_state;
      end
   end
   // ------------------------------------------------------------
   // Data path and pulses
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdata_reg <= CXE_ADDR_RST;
         dest_reg <= CXE_ADDR_RST;
         dest_we <= 1'b0;
         base_wb <= 1'b0;
         abandoned <= 1'b0;
      end else begin
         dest_we <= 1'b0;
         base_wb <= 1'b0;
         abandoned <= cp_abandon;
         if (state_reg == CXE_IDLE && op_valid) begin
            wdata_reg <= src_data;
         end
         if (state_reg == CXE_XFER && op_reg == CXE_OP_STORE) begin
            wdata_reg <= read_data;
         end
         if (cp_commit && is_mem_op) begin
            base_wb <= 1'b1;
         end
         if (state_reg == CXE_MOVE2 && op_reg == CXE_OP_TOCORE) begin
            dest_reg <= read_data;
            dest_we <= 1'b1;
         end
         if (state_reg == CXE_SWRD) begin
            dest_reg <= read_data;
         end
         if (state_reg == CXE_SWEND) begin
            dest_we <= 1'b1;
         end
      end
   end
   assign busy_seq = (state_reg != CXE_IDLE);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_swap_lock_held: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CXE_SWRD) |-> bus_lock ##1 bus_lock ##1 !bus_lock)
      else $error("lock not held over swap");
   a_swap_compressed: assert property (@(posedge ref_clk) disable iff (rst)
      (op_valid && state_reg == CXE_IDLE && compressed_state && op_code == CXE_OP_SWAP) |=> state_reg == CXE_UND2)
      else $error("swap accepted in compressed state");
   a_entry_link: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CXE_UND2) |=> link_register == $past(ret_base) && state_reg == CXE_EXC1)
      else $error("link register not saved");
   a_vector_fetch: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CXE_EXC1) |-> priv_access && !tbit_reg ##1 bus_addr == $past(bus_addr) + CXE_WORD_STEP)
      else $error("vector fetch sequence wrong");
   a_wait_reissue: assert property (@(posedge ref_clk) disable iff (rst)
      cp_wait && !irq_pending |-> !coproc_issue_n ##1 in_hand)
      else $error("wait did not re-present");
   a_abandon_irq: assert property (@(posedge ref_clk) disable iff (rst)
      cp_abandon |=> state_reg == CXE_IDLE && abandoned)
      else $error("abandon not taken");
   a_xfer_write: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CXE_XFER) |-> bus_write == (op_reg == CXE_OP_STORE) && coproc_issue_n)
      else $error("transfer write level wrong");
   a_last_nonseq: assert property (@(posedge ref_clk) disable iff (rst)
      last_xfer |-> next_cycle_type == CXE_CYC_NONSEQ ##1 state_reg == CXE_IDLE)
      else $error("last transfer not ended");
   a_refuse_undef: assert property (@(posedge ref_clk) disable iff (rst)
      cp_refuse |=> state_reg == CXE_UND2 ##1 state_reg == CXE_EXC1)
      else $error("refusal did not trap");
   a_move_dest: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CXE_MOVE2 && op_reg == CXE_OP_TOCORE) |=> dest_we && state_reg == CXE_MOVE3)
      else $error("move data not written");
   a_cmp_no_issue: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CXE_IDLE && op_valid && compressed_state) |-> coproc_issue_n)
      else $error("coprocessor issued in compressed state");
endmodule : cxe_seq

/* testbench/cxe_cp_model.sv */
// Purpose: Behavioural coprocessor on the far side of cxe_seq
// Assumes: Responses driven from ref_clk state and the qualifier
// Notes: Wait, burst length and refusal set by the bench
`timescale 1ns/1ps
module cxe_cp_model
   import cxe_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic rst, // Synchronous reset
   input wire logic coproc_issue_n, // Qualifier from core
   input wire logic [7:0] cfg_wait, // Busy-wait cycles
   input wire logic [3:0] cfg_words, // Words per burst
   input wire logic cfg_unable, // Refuse every instruction
   input wire logic [31:0] cp_word, // Data offered to core
   output logic coprocessor_absent, // Absent response
   output logic coprocessor_busy, // Busy response
   output logic [31:0] read_data // Coprocessor data
);
   logic committed_reg;
   logic held_reg;
   logic [7:0] wait_reg;
   logic [3:0] left_reg;
   logic engage;
   logic last;
   assign last = committed_reg && (left_reg == 4'h1);
   assign engage = !coproc_issue_n && !committed_reg;
   assign coprocessor_absent = committed_reg ? last : (engage ? cfg_unable : 1'h1);
   assign coprocessor_busy = committed_reg ? last : (engage ? (cfg_unable || wait_reg < cfg_wait) : 1'h1);
   // Data valid only around the committed window
   assign read_data = (committed_reg || held_reg) ? cp_word : ~cp_word;
   always @(posedge ref_clk) begin
      held_reg <= committed_reg;
      if (rst) begin
         committed_reg <= 1'h0;
         wait_reg <= 8'h00;
         left_reg <= 4'h0;
      end else if (committed_reg) begin
         left_reg <= left_reg - 4'h1;
         committed_reg <= !last;
      end else if (engage) begin
         wait_reg <= wait_reg + 8'h01;
         if (!coprocessor_absent && !coprocessor_busy) begin
            committed_reg <= 1'h1;
            left_reg <= cfg_words;
            wait_reg <= 8'h00;
         end
      end else begin
         wait_reg <= 8'h00;
      end
   end
endmodule : cxe_cp_model

/* testbench/cxe_seq_tb.sv */
// Purpose: Self-checking bench for cxe_seq
// Assumes: cxe_cp_model answers on the far side
// Notes: Per-operation counters gathered by a monitor
`timescale 1ns/1ps
module cxe_seq_tb
   import cxe_pkg::*;
();
   logic ref_clk = 1'h0, rst = 1'h1, op_valid = 1'h0, compressed_state = 1'h0, irq_pending = 1'h0;
   logic [2:0] op_code = 3'h0;
   logic [1:0] ret_kind = 2'h0;
   logic [4:0] exc_mode = 5'h13;
   logic [31:0] pc_base = 32'h0000_1000, data_addr = 32'h0000_8000, src_data = 32'h1234_5678;
   logic [31:0] vector_addr = 32'h0000_0004, status_word = 32'h6000_0010, cp_word = 32'hcafe_0042;
   logic [7:0] cfg_wait = 8'h00;
   logic [3:0] cfg_words = 4'h1;
   logic cfg_unable = 1'h0, coprocessor_absent, coprocessor_busy, bus_write, bus_lock, priv_access;
   logic coproc_issue_n, tbit_reg, dest_we, base_wb, abandoned, busy_seq, exp_wr = 1'h0, trk = 1'h0;
   logic [1:0] next_cycle_type;
   logic [4:0] mode_reg;
   logic [31:0] read_data, bus_addr, wdata_reg, link_register, saved_status_word, dest_reg, exp_addr;
   int mismatches = 0, comparisons = 0, cyc = 0;
   int n_iss, n_lock, n_c01, n_wr, n_dwe, n_wb, n_abn, n_vec0, n_vec4, n_words, n_bad;
   always #2.5 ref_clk = ~ref_clk;
   cxe_seq dut (.ref_clk, .rst, .op_valid, .op_code, .compressed_state, .pc_base, .data_addr, .src_data,
      .vector_addr, .exc_mode, .ret_kind, .status_word, .irq_pending, .coprocessor_absent, .coprocessor_busy,
      .read_data, .next_cycle_type, .bus_addr, .bus_write, .bus_lock, .priv_access, .coproc_issue_n,
      .wdata_reg, .link_register, .saved_status_word, .mode_reg, .tbit_reg, .dest_reg, .dest_we, .base_wb,
      .abandoned, .busy_seq);
   cxe_cp_model cp (.ref_clk, .rst, .coproc_issue_n, .cfg_wait, .cfg_words, .cfg_unable, .cp_word,
      .coprocessor_absent, .coprocessor_busy, .read_data);
   // ------------------------------------------------------------
   // Monitor and helpers
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (coproc_issue_n === 1'h0) n_iss++;
      if (bus_lock === 1'h1) n_lock++;
      if (next_cycle_type === CXE_CYC_COPROC) n_c01++;
      if (bus_write === 1'h1) n_wr++;
      if (dest_we === 1'h1) n_dwe++;
      if (base_wb === 1'h1) n_wb++;
      if (abandoned === 1'h1) n_abn++;
      if (priv_access === 1'h1 && bus_addr === vector_addr) n_vec0++;
      if (priv_access === 1'h1 && bus_addr === vector_addr + CXE_WORD_STEP) n_vec4++;
      if (trk && busy_seq === 1'h1 && coproc_issue_n === 1'h1 && bus_addr === exp_addr) begin
         n_words++;
         exp_addr = exp_addr + CXE_WORD_STEP;
         if (bus_write !== exp_wr) n_bad++;
      end
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report();
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic run_op(input logic [2:0] code);
      int i;
      {n_iss, n_lock, n_c01, n_wr, n_dwe, n_wb, n_abn, n_vec0, n_vec4, n_words, n_bad} = '0;
      exp_addr = data_addr;
      @(posedge ref_clk);
      op_valid <= 1'h1;
      op_code <= code;
      @(posedge ref_clk);
      op_valid <= 1'h0;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (busy_seq !== 1'h0 && i < 80);
      repeat (2) @(posedge ref_clk);
      chk(i < 80, 1);
   endtask : run_op
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_data(input logic [7:0] w);
      cfg_wait <= w;
      run_op(CXE_OP_DATA);
      chk(n_iss > int'(w), 1);
      chk(n_vec0, 0);
      chk(coproc_issue_n, 1);
   endtask : t_data
   task automatic t_absent();
      cfg_unable <= 1'h1;
      vector_addr <= CXE_VEC_UNDEF;
      for (int k = 0; k < 2; k++) begin
         run_op(k ? CXE_OP_UNDEF : CXE_OP_TOCP);
         chk(mode_reg, CXE_MODE_UNDEF);
         chk(saved_status_word, status_word);
         chk(tbit_reg, 0);
         chk(n_iss > 0, 1);
         chk(n_vec0 > 0 && n_vec4 > 0, 1);
      end
      cfg_unable <= 1'h0;
   endtask : t_absent
   task automatic t_trap();
      vector_addr <= 32'h0000_0008;
      for (int k = 0; k < 3; k++) begin
         ret_kind <= 2'(k);
         run_op(CXE_OP_TRAP);
         chk(link_register, pc_base + (k == 2 ? CXE_WORD_STEP : 32'h0000_0000));
         chk(mode_reg, exc_mode);
         chk(n_vec0 > 0 && n_vec4 > 0, 1);
      end
   endtask : t_trap
   task automatic t_burst(input logic [2:0] code, input logic [3:0] w, input logic wr);
      cfg_words <= w;
      exp_wr = wr;
      trk = 1'h1;
      run_op(code);
      trk = 1'h0;
      chk(n_words, w);
      chk(n_bad, 0);
      chk(n_wb, 1);
      if (wr) chk(wdata_reg, cp_word);
      cfg_words <= 4'h1;
   endtask : t_burst
   task automatic t_move();
      run_op(CXE_OP_TOCORE);
      chk(dest_reg, cp_word);
      chk(n_dwe, 1);
      run_op(CXE_OP_TOCP);
      chk(wdata_reg, src_data);
      chk(n_wr > 0 && n_c01 > 0, 1);
   endtask : t_move
   task automatic t_swap();
      run_op(CXE_OP_SWAP);
      chk(n_lock, 2);
      chk(n_dwe, 1);
   endtask : t_swap
   task automatic t_irq();
      cfg_wait <= 8'hc8;
      irq_pending <= 1'h1;
      run_op(CXE_OP_DATA);
      chk(n_abn, 1);
      irq_pending <= 1'h0;
      cfg_wait <= 8'h00;
   endtask : t_irq
   task automatic t_cmp();
      vector_addr <= CXE_VEC_UNDEF;
      compressed_state <= 1'h1;
      for (int k = 0; k < 6; k++) begin
         run_op(3'(k));
         chk(n_vec0 > 0 && n_lock == 0, 1);
         chk(n_iss, 0);
         chk(mode_reg, CXE_MODE_UNDEF);
      end
      compressed_state <= 1'h0;
   endtask : t_cmp
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'h0;
      chk(mode_reg, CXE_MODE_SVC);
      chk(saved_status_word, CXE_STATUS_RST);
      chk(next_cycle_type, CXE_CYC_IDLE);
      t_data(8'h00);
      t_data(8'h03);
      t_absent();
      t_trap();
      t_burst(CXE_OP_LOAD, 4'h3, 1'h0);
      t_burst(CXE_OP_STORE, 4'h2, 1'h1);
      t_burst(CXE_OP_LOAD, 4'h1, 1'h0);
      t_move();
      t_swap();
      t_irq();
      t_cmp();
      final_report();
   end
endmodule : cxe_seq_tb
